// ---- core/bus_quiet_timer.sv ----
// bus-quiet detector: counts idle cycles after the last outstanding transaction
// assumes axi_busy comes from logic on the same clock
`timescale 1ns/1ps
module bus_quiet_timer (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic axi_busy,
  input wire logic quiet_irq_enable,
  input wire logic [irq_route_pkg::QUIET_VAL_W-1:0] quiet_value,
  output logic quiet_request
);

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  logic [irq_route_pkg::QUIET_CNT_W-1:0] cnt_q;
  logic [irq_route_pkg::QUIET_CNT_W-1:0] cnt_d;
  logic [irq_route_pkg::QUIET_CNT_W-1:0] reload;
  logic at_zero;

  // value times sixteen plus fifteen is a shift with ones filled in
  assign reload = {quiet_value, irq_route_pkg::QUIET_FILL};
  assign at_zero = (cnt_q == '0);
  // holding at zero keeps the request up until traffic or software ends it
  assign cnt_d = axi_busy ? reload : (at_zero ? cnt_q : cnt_q - 1'b1);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= irq_route_pkg::QUIET_CNT_RESET;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign quiet_request = at_zero && quiet_irq_enable;

  a_quiet_reload: assert property (
    @(posedge mclk) disable iff (!arst_n) axi_busy |=> cnt_q == $past(reload))
    else $error("quiet counter not reloaded");
  a_quiet_countdown: assert property (
    @(posedge mclk) disable iff (!arst_n) (!axi_busy && cnt_q != '0) |=> cnt_q == $past(cnt_q) - 1'b1)
    else $error("quiet counter not decremented");

endmodule : bus_quiet_timer

// ---- core/irq_route_pkg.sv ----
// constants and carrier types for the local interrupt routing block
// assumes one clock domain and an avalon-mm register slave with 32-bit data
//
// Behaviour
// - 3-bit selector steers cache bus error
// - bus error forwarded only when mask bit is clear
// - mask bit one suppresses bus error
// - four core monitor requests routed by word
// - set view sets bits written one
// - clear view clears bits written one
// - upper nibble routes monitor to fast
// - lower nibble routes monitor to normal
// - fast route wins, never both inputs
// - 3-bit selector steers local tick
// - tick selector updates only with key 0x01
// - quiet bus raises core zero normal
// - outstanding traffic reloads sixteen times plus fifteen
// - counter decrements each idle clock edge down to zero, then holds
// - zero count requests only when enabled
// - quiet value twenty bits, sixteen-cycle units
package irq_route_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CLUSTER_CTRL = 8'h00;
  localparam logic [7:0] OFS_BUS_ERROR_ROUTE = 8'h0C;
  localparam logic [7:0] OFS_PM_SET = 8'h10;
  localparam logic [7:0] OFS_PM_CLEAR = 8'h14;
  localparam logic [7:0] OFS_TICK_ROUTE = 8'h24;
  localparam logic [7:0] OFS_QUIET_CTRL = 8'h30;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h80;
  localparam logic [7:0] OFS_EVT_CLEAR = 8'h84;
  localparam logic [7:0] OFS_EVT_ENABLE = 8'h88;

  // ---------------------------------------------------------------
  // field positions and widths
  // ---------------------------------------------------------------
  localparam int BUS_ERR_MASK_BIT = 6;
  localparam int BUS_ERR_SEL_LSB = 4;
  localparam int SEL_W = 3;
  localparam int PM_FAST_LSB = 4;
  localparam int PM_W = 8;
  localparam int KEY_LSB = 24;
  localparam int KEY_W = 8;
  localparam logic [7:0] TICK_KEY = 8'h01;
  localparam int QUIET_EN_BIT = 20;
  localparam int QUIET_VAL_W = 20;
  localparam int QUIET_CNT_W = 24;
  localparam logic [3:0] QUIET_FILL = 4'hF;
  localparam int EVT_W = 3;
  localparam int EVT_BUS_ERR = 0;
  localparam int EVT_QUIET = 1;
  localparam int EVT_TICK = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
  localparam logic [PM_W-1:0] PM_RESET = 8'h00;
  localparam logic [KEY_W-1:0] KEY_RESET = 8'h00;
  localparam logic [QUIET_VAL_W-1:0] QUIET_VAL_RESET = 20'h00000;
  localparam logic [QUIET_CNT_W-1:0] QUIET_CNT_RESET = 24'h00000F;

  // one request line per core, normal and fast
  typedef struct packed {
    logic [3:0] fast;
    logic [3:0] normal;
  } core_req_t;

endpackage : irq_route_pkg

// ---- core/local_irq_router.sv ----
// local interrupt routing for a four-core cluster with avalon-mm registers
// assumes all request inputs are on mclk; cores sample the registered outputs
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module local_irq_router (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic bus_error_request,
  input wire logic [3:0] perfmon_core_request,
  input wire logic local_tick_request,
  input wire logic axi_busy,
  output logic [3:0] core_normal_request,
  output logic [3:0] core_fast_request,
  output logic irq_out
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // 3-bit selector to one request line: 0..3 normal, 4..7 fast
  function automatic irq_route_pkg::core_req_t sel_route(
    input logic [irq_route_pkg::SEL_W-1:0] sel,
    input logic req
  );
    irq_route_pkg::core_req_t r;
    r = '0;
    if (sel[2]) begin
      r.fast[sel[1:0]] = req;
    end else begin
      r.normal[sel[1:0]] = req;
    end
    return r;
  endfunction : sel_route

  // byte enables widened to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : lane_mask

  // ---------------------------------------------------------------
  // bus slave handshake
  // ---------------------------------------------------------------
  logic ack_q;
  logic [31:0] rdata_q;
  logic req_any;
  logic wr_go;
  logic [31:0] wmask;
  logic [31:0] wbits;

  // one wait cycle per access; the access completes when ack_q is high
  assign req_any = avs_read || avs_write;
  assign avs_waitrequest = req_any && !ack_q;
  assign wr_go = avs_write && ack_q;
  assign wmask = lane_mask(avs_byteenable);
  assign wbits = avs_writedata & wmask;
  assign avs_readdata = rdata_q;

  // named write strobes
  logic wr_cluster;
  logic wr_be_route;
  logic wr_pm_set;
  logic wr_pm_clear;
  logic wr_tick;
  logic wr_quiet;
  logic wr_evt_clear;
  logic wr_evt_enable;

  assign wr_cluster = wr_go && avs_address == irq_route_pkg::OFS_CLUSTER_CTRL;
  assign wr_be_route = wr_go && avs_address == irq_route_pkg::OFS_BUS_ERROR_ROUTE;
  assign wr_pm_set = wr_go && avs_address == irq_route_pkg::OFS_PM_SET;
  assign wr_pm_clear = wr_go && avs_address == irq_route_pkg::OFS_PM_CLEAR;
  assign wr_tick = wr_go && avs_address == irq_route_pkg::OFS_TICK_ROUTE;
  assign wr_quiet = wr_go && avs_address == irq_route_pkg::OFS_QUIET_CTRL;
  assign wr_evt_clear = wr_go && avs_address == irq_route_pkg::OFS_EVT_CLEAR;
  assign wr_evt_enable = wr_go && avs_address == irq_route_pkg::OFS_EVT_ENABLE;

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic bus_error_mask_q;
  logic [irq_route_pkg::SEL_W-1:0] be_sel_q;
  logic [irq_route_pkg::PM_W-1:0] pm_word_q;
  logic [irq_route_pkg::PM_W-1:0] pm_word_d;
  logic [irq_route_pkg::KEY_W-1:0] tick_key_q;
  logic [irq_route_pkg::SEL_W-1:0] tick_sel_q;
  logic tick_key_ok;
  logic quiet_irq_enable_q;
  logic [irq_route_pkg::QUIET_VAL_W-1:0] quiet_value_q;
  logic [irq_route_pkg::EVT_W-1:0] evt_enable_q;

  // the set and clear views share one word; set and clear at one address never meet
  assign pm_word_d = wr_pm_set ? (pm_word_q | wbits[irq_route_pkg::PM_W-1:0]) :
                     wr_pm_clear ? (pm_word_q & ~wbits[irq_route_pkg::PM_W-1:0]) :
                     pm_word_q;

  // key is judged on the whole write, so the top byte lane must be enabled
  assign tick_key_ok = avs_byteenable[3] &&
                       avs_writedata[irq_route_pkg::KEY_LSB +: irq_route_pkg::KEY_W] == irq_route_pkg::TICK_KEY;

  // plain read/write control, all cleared by reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bus_error_mask_q <= 1'b0;
      be_sel_q <= irq_route_pkg::SEL_RESET;
      pm_word_q <= irq_route_pkg::PM_RESET;
      tick_key_q <= irq_route_pkg::KEY_RESET;
      tick_sel_q <= irq_route_pkg::SEL_RESET;
      quiet_irq_enable_q <= 1'b0;
      quiet_value_q <= irq_route_pkg::QUIET_VAL_RESET;
      evt_enable_q <= '0;
    end else begin
      if (wr_cluster && avs_byteenable[0]) begin
        bus_error_mask_q <= avs_writedata[irq_route_pkg::BUS_ERR_MASK_BIT];
      end
      if (wr_be_route && avs_byteenable[0]) begin
        be_sel_q <= avs_writedata[irq_route_pkg::BUS_ERR_SEL_LSB +: irq_route_pkg::SEL_W];
      end
      pm_word_q <= pm_word_d;
      if (wr_tick && avs_byteenable[3]) begin
        tick_key_q <= avs_writedata[irq_route_pkg::KEY_LSB +: irq_route_pkg::KEY_W];
      end
      if (wr_tick && avs_byteenable[0] && tick_key_ok) begin
        tick_sel_q <= avs_writedata[irq_route_pkg::SEL_W-1:0];
      end
      if (wr_quiet && avs_byteenable[2]) begin
        quiet_irq_enable_q <= avs_writedata[irq_route_pkg::QUIET_EN_BIT];
      end
      if (wr_quiet) begin
        quiet_value_q <= (quiet_value_q & ~wmask[irq_route_pkg::QUIET_VAL_W-1:0]) |
                         wbits[irq_route_pkg::QUIET_VAL_W-1:0];
      end
      if (wr_evt_enable) begin
        evt_enable_q <= (evt_enable_q & ~wmask[irq_route_pkg::EVT_W-1:0]) | wbits[irq_route_pkg::EVT_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // routing
  // ---------------------------------------------------------------
  logic [3:0] pm_fast_mask;
  logic [3:0] pm_normal_mask;
  logic bus_error_live;
  logic quiet_request;
  irq_route_pkg::core_req_t be_route;
  irq_route_pkg::core_req_t tick_route;
  irq_route_pkg::core_req_t pm_route;
  irq_route_pkg::core_req_t all_route;

  assign pm_fast_mask = pm_word_q[irq_route_pkg::PM_FAST_LSB +: 4];
  assign pm_normal_mask = pm_word_q[3:0];
  // mask bit set means the error never leaves the block
  assign bus_error_live = bus_error_request && !bus_error_mask_q;
  assign be_route = sel_route(be_sel_q, bus_error_live);
  assign tick_route = sel_route(tick_sel_q, local_tick_request);
  // each core's monitor request is routed to its own inputs only
  assign pm_route.fast = perfmon_core_request & pm_fast_mask;
  assign pm_route.normal = perfmon_core_request & pm_normal_mask & ~pm_fast_mask;
  assign all_route.fast = be_route.fast | tick_route.fast | pm_route.fast;
  assign all_route.normal = be_route.normal | tick_route.normal | pm_route.normal |
                            {3'h0, quiet_request};

  bus_quiet_timer u_quiet (
    .mclk(mclk),
    .arst_n(arst_n),
    .axi_busy(axi_busy),
    .quiet_irq_enable(quiet_irq_enable_q),
    .quiet_value(quiet_value_q),
    .quiet_request(quiet_request)
  );

  // registered requests: one cycle of latency, clean edges at the cores
  irq_route_pkg::core_req_t out_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      out_q <= '0;
    end else begin
      out_q <= all_route;
    end
  end

  assign core_normal_request = out_q.normal;
  assign core_fast_request = out_q.fast;

  // ---------------------------------------------------------------
  // event status and interrupt
  // ---------------------------------------------------------------
  logic [irq_route_pkg::EVT_W-1:0] evt_set;
  logic [irq_route_pkg::EVT_W-1:0] evt_clr;
  logic [irq_route_pkg::EVT_W-1:0] evt_status_q;

  assign evt_set = {local_tick_request, quiet_request, bus_error_live};
  assign evt_clr = wr_evt_clear ? wbits[irq_route_pkg::EVT_W-1:0] : '0;

  // a new event in the clear cycle survives: set wins over clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      evt_status_q <= '0;
    end else begin
      evt_status_q <= (evt_status_q & ~evt_clr) | evt_set;
    end
  end

  assign irq_out = |(evt_status_q & evt_enable_q);

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  assign rd_mux =
    avs_address == irq_route_pkg::OFS_CLUSTER_CTRL ?
      32'(bus_error_mask_q) << irq_route_pkg::BUS_ERR_MASK_BIT :
    avs_address == irq_route_pkg::OFS_BUS_ERROR_ROUTE ?
      32'(be_sel_q) << irq_route_pkg::BUS_ERR_SEL_LSB :
    (avs_address == irq_route_pkg::OFS_PM_SET || avs_address == irq_route_pkg::OFS_PM_CLEAR) ?
      32'(pm_word_q) :
    avs_address == irq_route_pkg::OFS_TICK_ROUTE ?
      {tick_key_q, 21'h00000, tick_sel_q} :
    avs_address == irq_route_pkg::OFS_QUIET_CTRL ?
      {11'h000, quiet_irq_enable_q, quiet_value_q} :
    avs_address == irq_route_pkg::OFS_EVT_STATUS ? 32'(evt_status_q) :
    avs_address == irq_route_pkg::OFS_EVT_ENABLE ? 32'(evt_enable_q) :
    32'h00000000; // unmapped and write-only read as zero

  // read data is sampled in the wait cycle and stands through the completing edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= req_any && !ack_q;
      rdata_q <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // a masked error leaves only the other sources on the cores
  a_be_masked_off: assert property (
    bus_error_mask_q |=> (out_q & ~$past(tick_route) & ~$past(pm_route)) == $past({4'h0, 3'h0, quiet_request}))
    else $error("masked bus error reached a core");

  // selector values 0..3 land on a normal input
  a_be_route_sel: assert property (
    (bus_error_live && !be_sel_q[2]) |=> out_q.normal[$past(be_sel_q[1:0])])
    else $error("bus error not on selected normal input");

  // selector values 4..7 land on a fast input
  a_be_route_fast: assert property (
    (bus_error_live && be_sel_q[2]) |=> out_q.fast[$past(be_sel_q[1:0])])
    else $error("bus error not on selected fast input");

  // set view: ones written become ones
  a_pm_set_bits: assert property (
    (wr_pm_set && avs_byteenable[0]) |=> (pm_word_q & $past(avs_writedata[7:0])) == $past(avs_writedata[7:0]))
    else $error("set view failed to set bits");

  // clear view: ones written become zeros
  a_pm_clear_bits: assert property (
    (wr_pm_clear && avs_byteenable[0]) |=> (pm_word_q & $past(avs_writedata[7:0])) == 8'h00)
    else $error("clear view failed to clear bits");

  // clear view leaves bits written as zero alone
  a_pm_hold_other: assert property (
    (wr_pm_clear && avs_byteenable[0]) |=> (pm_word_q & ~$past(avs_writedata[7:0])) ==
      ($past(pm_word_q) & ~$past(avs_writedata[7:0])))
    else $error("clear view disturbed other bits");

  // a fast-routed request never shows on the normal input when nothing else drives it
  a_pm_fast_only: assert property (
    (perfmon_core_request[0] && pm_fast_mask[0] && !be_route.normal[0] && !tick_route.normal[0]
      && !quiet_request) |=> out_q.fast[0] && !out_q.normal[0])
    else $error("monitor request on both inputs");

  // a fast mask bit puts the core's request on its own fast input
  a_pm_fast_route: assert property (
    (perfmon_core_request[2] && pm_fast_mask[2]) |=> out_q.fast[2])
    else $error("monitor request missing on fast input");

  // normal mask alone routes to the normal input
  a_pm_normal: assert property (
    (perfmon_core_request[1] && pm_normal_mask[1] && !pm_fast_mask[1]) |=> out_q.normal[1])
    else $error("monitor request missing on normal input");

  // a write without the key leaves the selector alone
  a_tick_key_hold: assert property (
    (wr_tick && !tick_key_ok) |=> $stable(tick_sel_q))
    else $error("tick selector changed without key");

  // the right key with the low lane loads the selector
  a_tick_key_load: assert property (
    (wr_tick && tick_key_ok && avs_byteenable[0]) |=> tick_sel_q == $past(avs_writedata[2:0]))
    else $error("tick selector ignored a keyed write");

  // selector 7 is core three's fast input
  a_tick_route: assert property (
    (local_tick_request && tick_sel_q == 3'h7) |=> out_q.fast[3])
    else $error("tick not on core three fast input");

  // selector values 0..3 put the tick on a normal input
  a_tick_route_normal: assert property (
    (local_tick_request && !tick_sel_q[2]) |=> out_q.normal[$past(tick_sel_q[1:0])])
    else $error("tick not on selected normal input");

  // with the enable low the timer never reaches core zero
  a_quiet_enable: assert property (
    (!quiet_irq_enable_q && !be_route.normal[0] && !tick_route.normal[0] && !pm_route.normal[0])
      |=> !out_q.normal[0])
    else $error("quiet request while disabled");

  // an enabled expiry reaches core zero one cycle later
  a_quiet_fire: assert property (
    quiet_request |=> out_q.normal[0])
    else $error("quiet request not delivered");

  // holding at zero keeps the request up while idle
  a_quiet_persist: assert property (
    (quiet_request && !axi_busy && !wr_quiet) |=> quiet_request)
    else $error("quiet request dropped while idle");

  // every access is answered after exactly one wait cycle
  a_wait_one: assert property (
    (req_any && avs_waitrequest) |=> !avs_waitrequest)
    else $error("access not answered after one wait cycle");

  // a live error keeps its status bit set, even under a clear
  a_evt_set_wins: assert property (
    bus_error_live |=> evt_status_q[irq_route_pkg::EVT_BUS_ERR])
    else $error("bus error event lost");

endmodule : local_irq_router

// ---- verif/core_model.sv ----
// behavioural model of the four cores on the routed request side
// assumes the cores share mclk with the router and raise monitor requests on it
`timescale 1ns/1ps
module core_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [3:0] pm_cmd,
  input wire logic [3:0] core_normal_request,
  input wire logic [3:0] core_fast_request,
  output logic [3:0] perfmon_core_request,
  output int rise_count
);
  // ---------------------------------------------------------------
  // monitor request outputs and delivered-request tally
  // ---------------------------------------------------------------
  logic [7:0] seen_q;
  // each core presents one monitor request, launched from its own flop
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      perfmon_core_request <= 4'h0;
      seen_q <= 8'h00;
      rise_count <= 0;
    end else begin
      perfmon_core_request <= pm_cmd;
      seen_q <= {core_fast_request, core_normal_request};
      if (({core_fast_request, core_normal_request} & ~seen_q) != 8'h00) begin
        rise_count <= rise_count + 1;
      end
    end
  end
endmodule : core_model

// ---- verif/testbench.sv ----
// self-checking bench for the local interrupt router
// assumes one 200 MHz clock; the bench acts as avalon-mm master and request sources
`timescale 1ns/1ps
module testbench;
  // ---------------------------------------------------------------
  // stimulus, clock and instances
  // ---------------------------------------------------------------
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic bus_error_request = 1'b0;
  logic [3:0] pm_cmd = 4'h0;
  logic [3:0] perfmon_core_request;
  logic local_tick_request = 1'b0;
  logic axi_busy = 1'b0;
  logic [3:0] core_normal_request;
  logic [3:0] core_fast_request;
  logic irq_out;
  logic [31:0] rd;
  int rise_count;
  int errors = 0;
  int checks = 0;
  // half period of 2.5 ns gives 200 MHz
  always #2.5 mclk = ~mclk;
  local_irq_router u_dut (.mclk(mclk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus_error_request(bus_error_request),
    .perfmon_core_request(perfmon_core_request), .local_tick_request(local_tick_request), .axi_busy(axi_busy),
    .core_normal_request(core_normal_request), .core_fast_request(core_fast_request), .irq_out(irq_out));
  core_model u_cores (.mclk(mclk), .arst_n(arst_n), .pm_cmd(pm_cmd), .core_normal_request(core_normal_request),
    .core_fast_request(core_fast_request), .perfmon_core_request(perfmon_core_request), .rise_count(rise_count));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk
  // one avalon cycle; waitrequest and read data are taken at the completing rising edge, before its updates land
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    logic done;
    done = 1'b0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (i = 0; i < 50 && !done; i++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) begin
        done = 1'b1;
        rd = avs_readdata;
      end
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (!done) begin
      errors++;
      $display("mismatch at %0t: bus cycle never completed", $time);
    end
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000);
    chk(rd, exp, "register read");
  endtask : rdchk
  // routed outputs are registered, so one edge passes before looking
  task automatic outs(input logic [7:0] exp);
    @(posedge mclk);
    @(negedge mclk);
    chk({24'h000000, core_fast_request, core_normal_request}, {24'h000000, exp}, "core requests");
  endtask : outs
  function automatic logic [7:0] dest(input logic [2:0] sel);
    dest = sel[2] ? {4'h1 << sel[1:0], 4'h0} : {4'h0, 4'h1 << sel[1:0]};
  endfunction : dest
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] ofs [8];
    ofs = '{8'h00, 8'h0C, 8'h10, 8'h14, 8'h24, 8'h30, 8'h88, 8'h40};
    foreach (ofs[i]) rdchk(ofs[i], 32'h00000000);
    outs(8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_bus_error;
    @(posedge mclk);
    bus_error_request <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, irq_route_pkg::OFS_BUS_ERROR_ROUTE, 32'(s) << 4);
      outs(dest(3'(s)));
    end
    rdchk(irq_route_pkg::OFS_BUS_ERROR_ROUTE, 32'h00000070);
    bus(1'b1, irq_route_pkg::OFS_CLUSTER_CTRL, 32'h00000040);
    outs(8'h00);
    bus(1'b1, irq_route_pkg::OFS_CLUSTER_CTRL, 32'h00000000);
    outs(8'h80);
    rdchk(irq_route_pkg::OFS_EVT_STATUS, 32'h00000001);
    bus(1'b1, irq_route_pkg::OFS_EVT_ENABLE, 32'h00000001);
    @(negedge mclk);
    chk({31'h0, irq_out}, 32'h00000001, "irq raised");
    bus(1'b1, irq_route_pkg::OFS_EVT_ENABLE, 32'h00000000);
    bus_error_request <= 1'b0;
    @(negedge mclk);
    chk({31'h0, irq_out}, 32'h00000000, "irq masked");
    bus(1'b1, irq_route_pkg::OFS_EVT_CLEAR, 32'h00000001);
    rdchk(irq_route_pkg::OFS_EVT_STATUS, 32'h00000000);
    bus(1'b1, irq_route_pkg::OFS_EVT_ENABLE, 32'h00000001);
    @(negedge mclk);
    chk({31'h0, irq_out}, 32'h00000000, "irq cleared");
    $display("test bus error done");
  endtask : t_bus_error
  task automatic t_perfmon;
    int r0;
    r0 = rise_count;
    @(posedge mclk);
    pm_cmd <= 4'hF;
    bus(1'b1, irq_route_pkg::OFS_PM_SET, 32'h0000000F);
    rdchk(irq_route_pkg::OFS_PM_SET, 32'h0000000F);
    outs(8'h0F);
    bus(1'b1, irq_route_pkg::OFS_PM_SET, 32'h00000051);
    rdchk(irq_route_pkg::OFS_PM_CLEAR, 32'h0000005F);
    outs(8'h5A);
    bus(1'b1, irq_route_pkg::OFS_PM_CLEAR, 32'h00000003);
    rdchk(irq_route_pkg::OFS_PM_SET, 32'h0000005C);
    outs(8'h58);
    bus(1'b1, irq_route_pkg::OFS_PM_CLEAR, 32'h000000FF);
    outs(8'h00);
    pm_cmd <= 4'h0;
    chk({31'h0, rise_count > r0}, 32'h00000001, "cores saw requests");
    $display("test perfmon done");
  endtask : t_perfmon
  task automatic t_tick;
    logic [7:0] bad [3];
    bad = '{8'h00, 8'h02, 8'h81};
    @(posedge mclk);
    local_tick_request <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, irq_route_pkg::OFS_TICK_ROUTE, 32'h01000000 | 32'(s));
      outs(dest(3'(s)));
    end
    // a wrong key must leave the core 3 fast route in place
    foreach (bad[i]) begin
      bus(1'b1, irq_route_pkg::OFS_TICK_ROUTE, {bad[i], 24'h000001});
      outs(8'h80);
    end
    local_tick_request <= 1'b0;
    $display("test tick done");
  endtask : t_tick
  task automatic t_quiet;
    int v;
    v = 2;
    bus(1'b1, irq_route_pkg::OFS_QUIET_CTRL, 32'h000FFFFF);
    rdchk(irq_route_pkg::OFS_QUIET_CTRL, 32'h000FFFFF);
    // busy first, since an idle counter has long since reached zero
    axi_busy <= 1'b1;
    bus(1'b1, irq_route_pkg::OFS_QUIET_CTRL, 32'h00100000 | 32'(v));
    @(posedge mclk);
    axi_busy <= 1'b0;
    repeat (16 * v + 15) @(posedge mclk);
    @(negedge mclk);
    chk({31'h0, core_normal_request[0]}, 32'h00000000, "quiet early");
    @(posedge mclk);
    @(negedge mclk);
    chk({31'h0, core_normal_request[0]}, 32'h00000001, "quiet fired");
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    chk({31'h0, core_normal_request[0]}, 32'h00000001, "quiet held");
    @(posedge mclk);
    axi_busy <= 1'b1;
    @(posedge mclk);
    axi_busy <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk({31'h0, core_normal_request[0]}, 32'h00000000, "quiet reload");
    bus(1'b1, irq_route_pkg::OFS_QUIET_CTRL, 32'(v));
    repeat (16 * v + 20) @(posedge mclk);
    @(negedge mclk);
    chk({31'h0, core_normal_request[0]}, 32'h00000000, "quiet disabled");
    $display("test quiet done");
  endtask : t_quiet
  // ---------------------------------------------------------------
  // verdict and main sequence
  // ---------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  // the tests take a few hundred cycles; 20000 leaves ample margin
  initial begin
    #100000;
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    complete_run();
  end
  initial begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_bus_error();
    t_perfmon();
    t_tick();
    t_quiet();
    complete_run();
  end
endmodule : testbench
